// [verilog/mag_cfg_pkg.sv]
// constants for the magnetometer configuration and threshold interrupt bank
// assumes the serial front end presents one byte-wide register access per cycle
package mag_cfg_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_CONFIG_B    = 8'h61;
	localparam logic [7:0] ADDR_CONFIG_C    = 8'h62;
	localparam logic [7:0] ADDR_IRQ_CONTROL = 8'h63;
	localparam logic [7:0] ADDR_IRQ_SOURCE  = 8'h64;
	localparam logic [7:0] ADDR_THRESH_LOW  = 8'h65;
	localparam logic [7:0] ADDR_THRESH_HIGH = 8'h66;
	localparam logic [7:0] ADDR_DATA_FIRST  = 8'h68;
	localparam logic [7:0] ADDR_DATA_LAST   = 8'h6d;

	// mag_config_b fields
	localparam int B_ONESHOT_OFFSET = 4;
	localparam int B_IRQ_HARDIRON   = 3;
	localparam int B_SET_RATE       = 2;
	localparam int B_OFFSET_EN      = 1;
	localparam int B_LOWPASS        = 0;
	localparam logic [7:0] CONFIG_B_MASK = 8'h1f;

	// mag_config_c fields
	localparam int C_IRQ_TO_PIN   = 6;
	localparam int C_TWO_WIRE_OFF = 5;
	localparam int C_COHERENT     = 4;
	localparam int C_BYTE_SWAP    = 3;
	localparam int C_SELF_TEST    = 1;
	localparam int C_DATA_READY_PIN_OUT_EN  = 0;
	localparam logic [7:0] CONFIG_C_MASK = 8'h7b;

	// mag_irq_control fields; axis enables sit at 7 - axis
	localparam int I_AXIS_TOP  = 7;
	localparam int I_POLARITY  = 2;
	localparam int I_LATCH     = 1;
	localparam int I_GLOBAL_ON = 0;
	localparam logic [7:0] IRQ_CONTROL_MASK = 8'he7;

	// mag_irq_source fields; positive at 7 - axis, negative at 4 - axis
	localparam int S_POS_TOP  = 7;
	localparam int S_NEG_TOP  = 4;
	localparam int S_OVERFLOW = 1;
	localparam int S_INT      = 0;

	// reset values
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [15:0] RESET_WORD = 16'h0000;

	// set pulse issued once every this many output data periods
	localparam logic [5:0] SET_PULSE_PERIOD = 6'h3f;
	localparam logic [5:0] SET_COUNT_ONE    = 6'h01;
	localparam logic [5:0] SET_COUNT_ZERO   = 6'h00;
endpackage

// [verilog/mag_config_threshold_irq.sv]
// magnetometer configuration, data read-out and threshold interrupt register bank
// assumes the spi/i2c front end decodes frames into single-cycle register accesses
// and that measurement results arrive as one-cycle pulses with stable data
//
// Behaviour
// RULE_01 - one-shot offset cancel needs general enable too
// RULE_02 - hard-iron bit selects corrected interrupt data
// RULE_03 - set pulse every 63 periods, else power-on
// RULE_04 - lowpass bit selects quarter versus half bandwidth
// RULE_05 - interrupt-to-pin bit drives flag onto pin
// RULE_06 - two-wire off ignores i2c register accesses
// RULE_07 - coherent lock keeps byte pairs from one update
// RULE_08 - byte swap exchanges low and high bytes
// RULE_09 - self-test bit enables magnetometer self-test
// RULE_10 - data_ready_pin enable makes data-ready pin output
// RULE_11 - host writes zero to reserved bits
// RULE_12 - per-axis interrupt enables, default off
// RULE_13 - polarity bit sets active level of flag
// RULE_14 - latch bit: pulsed or held until read
// RULE_15 - latched source register cleared on read
// RULE_16 - global enable gates all threshold interrupts
// RULE_17 - per-axis positive and negative exceed flags
// RULE_18 - overflow flag always generated, cleared on read
// RULE_19 - summary interrupt flag in source register
// RULE_20 - low threshold byte holds bits 7:0
// RULE_21 - unsigned 16-bit threshold, both signs compared
// RULE_22 - pulsed flag lasts one measurement only
`timescale 1ns/100ps
module mag_config_threshold_irq (
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic        reg_write_in,
	input  wire logic        reg_read_in,
	input  wire logic [7:0]  reg_wdata_in,
	input  wire logic        reg_from_i2c_in,
	output logic      [7:0]  reg_rdata_out,
	input  wire logic        meas_valid_in,
	input  wire logic [15:0] raw_x_in,
	input  wire logic [15:0] raw_y_in,
	input  wire logic [15:0] raw_z_in,
	input  wire logic [15:0] offset_x_in,
	input  wire logic [15:0] offset_y_in,
	input  wire logic [15:0] offset_z_in,
	input  wire logic        range_overflow_in,
	input  wire logic        power_on_in,
	output logic             set_pulse_out,
	output logic             offset_cancel_en_out,
	output logic             oneshot_offset_cancel_out,
	output logic             lowpass_en_out,
	output logic             self_test_out,
	output logic             data_ready_pin_output_en_out,
	output logic             data_ready_pin_out,
	output logic             irq_pin_out
);
	import mag_cfg_pkg::*;

	logic [7:0]  mag_config_b;
	logic [7:0]  mag_config_c;
	logic [7:0]  mag_irq_control;
	logic [7:0]  mag_threshold_low;
	logic [7:0]  mag_threshold_high;
	logic [2:0]  pos_flag;
	logic [2:0]  neg_flag;
	logic        overflow_flag;
	logic        int_active;
	logic [15:0] latest [3];
	logic [15:0] held [3];
	logic        locked;
	logic [1:0]  lock_axis;
	logic [5:0]  set_count;
	logic        data_new;

	logic        access_ok;
	logic        do_write;
	logic        do_read;
	logic        read_source;
	logic        read_data;
	logic [2:0]  rd_axis;
	logic        rd_high;
	logic [2:0]  pos_hit;
	logic [2:0]  neg_hit;
	logic        int_event;
	logic        latch_mode;
	logic        lock_start;
	logic        int_bit;
	logic [7:0]  source_value;
	logic [7:0]  next_rdata;
	logic [15:0] rd_word;
	logic [16:0] thresh_ext;
	logic [15:0] raw_in [3];
	logic [15:0] offs_in [3];

	assign raw_in[0]  = raw_x_in;
	assign raw_in[1]  = raw_y_in;
	assign raw_in[2]  = raw_z_in;
	assign offs_in[0] = offset_x_in;
	assign offs_in[1] = offset_y_in;
	assign offs_in[2] = offset_z_in;

	// access qualification and decode
	// RULE_06 i2c access gate
	assign access_ok   = !(reg_from_i2c_in && mag_config_c[C_TWO_WIRE_OFF]);
	assign do_write    = reg_write_in && access_ok;
	assign do_read     = reg_read_in && access_ok;
	assign read_source = do_read && (reg_addr_in == ADDR_IRQ_SOURCE);
	assign read_data   = do_read && (reg_addr_in >= ADDR_DATA_FIRST)
		&& (reg_addr_in <= ADDR_DATA_LAST);
	assign rd_axis     = 3'((reg_addr_in - ADDR_DATA_FIRST) >> 1);
	assign rd_high     = reg_addr_in[0];
	assign latch_mode  = mag_irq_control[I_LATCH];

	// a data read under coherent lock freezes the copies at this very edge;
	// letting the copy move here would hand back a low byte from one sample
	// and leave its high byte from the next one
	// RULE_07 freeze on first byte
	assign lock_start  = read_data && mag_config_c[C_COHERENT];

	// RULE_20 threshold low byte
	// RULE_21 unsigned magnitude, one extra bit for the signed compare
	assign thresh_ext = {1'b0, mag_threshold_high, mag_threshold_low};

	// per-axis data path and threshold compare
	genvar ax;
	generate
		for (ax = 0; ax < 3; ax++) begin : g_axis
			logic signed [16:0] corrected;
			logic signed [16:0] checked;
			// RULE_02 choose corrected or raw
			assign corrected = 17'(signed'(raw_in[ax])) - 17'(signed'(offs_in[ax]));
			assign checked   = mag_config_b[B_IRQ_HARDIRON] ? corrected
				: 17'(signed'(raw_in[ax]));
			// RULE_17 exceed on either side
			// RULE_12 axis enable gate
			assign pos_hit[ax] = mag_irq_control[I_AXIS_TOP - ax]
				&& (checked > signed'(thresh_ext));
			assign neg_hit[ax] = mag_irq_control[I_AXIS_TOP - ax]
				&& (checked < -signed'(thresh_ext));

			// newest corrected sample, wrapped to the output width
			always_ff @(posedge clk_in) begin
				if (reset_in) begin
					latest[ax] <= RESET_WORD;
				end else if (meas_valid_in) begin
					latest[ax] <= corrected[15:0];
				end
			end
		end
	endgenerate

	// RULE_16 global enable gate
	assign int_event = mag_irq_control[I_GLOBAL_ON] && (|pos_hit || |neg_hit);

	// RULE_13 reported level follows polarity
	assign int_bit = mag_irq_control[I_POLARITY] ? int_active : !int_active;
	assign source_value = {pos_flag[0], pos_flag[1], pos_flag[2],
		neg_flag[0], neg_flag[1], neg_flag[2], overflow_flag, int_bit};

	// config register writes; reserved bits are dropped and read as zero
	// RULE_11 reserved bits masked
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			mag_config_b       <= RESET_BYTE;
			mag_config_c       <= RESET_BYTE;
			mag_irq_control    <= RESET_BYTE;
			mag_threshold_low  <= RESET_BYTE;
			mag_threshold_high <= RESET_BYTE;
		end else if (do_write) begin
			unique case (reg_addr_in)
				ADDR_CONFIG_B:    mag_config_b <= reg_wdata_in & CONFIG_B_MASK;
				ADDR_CONFIG_C:    mag_config_c <= reg_wdata_in & CONFIG_C_MASK;
				ADDR_IRQ_CONTROL: mag_irq_control <= reg_wdata_in & IRQ_CONTROL_MASK;
				ADDR_THRESH_LOW:  mag_threshold_low <= reg_wdata_in;
				ADDR_THRESH_HIGH: mag_threshold_high <= reg_wdata_in;
				default: ;
			endcase
		end
	end

	// axis flags and summary flag; in latched mode a new event beats the read clear
	// RULE_14 latched or pulsed
	// RULE_15 clear on read
	// RULE_22 pulsed lasts one measurement
	// RULE_19 summary flag
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			pos_flag   <= 3'h0;
			neg_flag   <= 3'h0;
			int_active <= 1'b0;
		end else if (latch_mode) begin
			if (meas_valid_in) begin
				pos_flag   <= (read_source ? 3'h0 : pos_flag) | (int_event ? pos_hit : 3'h0);
				neg_flag   <= (read_source ? 3'h0 : neg_flag) | (int_event ? neg_hit : 3'h0);
				int_active <= (int_active && !read_source) || int_event;
			end else if (read_source) begin
				pos_flag   <= 3'h0;
				neg_flag   <= 3'h0;
				int_active <= 1'b0;
			end
		end else if (meas_valid_in) begin
			pos_flag   <= int_event ? pos_hit : 3'h0;
			neg_flag   <= int_event ? neg_hit : 3'h0;
			int_active <= int_event;
		end
	end

	// overflow flag ignores every enable; a new overflow beats the read clear
	// RULE_18 overflow flag
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			overflow_flag <= 1'b0;
		end else if (meas_valid_in && range_overflow_in) begin
			overflow_flag <= 1'b1;
		end else if (read_source) begin
			overflow_flag <= 1'b0;
		end
	end

	// coherent lock: first byte read of a word freezes it until its partner is read;
	// new samples wait in latest, each overwriting the one before, so only the newest reaches the copies once unlocked
	// RULE_07 hold pair coherent
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			locked    <= 1'b0;
			lock_axis <= 2'h0;
		end else if (!mag_config_c[C_COHERENT]) begin
			locked <= 1'b0;
		end else if (read_data) begin
			if (locked && (lock_axis == rd_axis[1:0])) begin
				locked <= 1'b0;
			end else begin
				locked    <= 1'b1;
				lock_axis <= rd_axis[1:0];
			end
		end
	end

	// read-out copies follow the newest sample whenever not frozen; the copy pauses
	// at the edge of a freezing read too, so a sample landing then waits in latest
	// and never splits a byte pair
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			held[0] <= RESET_WORD;
			held[1] <= RESET_WORD;
			held[2] <= RESET_WORD;
		end else if (!locked && !lock_start) begin
			held[0] <= latest[0];
			held[1] <= latest[1];
			held[2] <= latest[2];
		end
	end

	// read mux; an ignored or unmapped read returns zero
	// RULE_08 byte swap on read
	always_comb begin
		rd_word    = held[rd_axis[1:0]];
		next_rdata = RESET_BYTE;
		if (do_read) begin
			unique case (reg_addr_in)
				ADDR_CONFIG_B:    next_rdata = mag_config_b;
				ADDR_CONFIG_C:    next_rdata = mag_config_c;
				ADDR_IRQ_CONTROL: next_rdata = mag_irq_control;
				ADDR_IRQ_SOURCE:  next_rdata = source_value;
				ADDR_THRESH_LOW:  next_rdata = mag_threshold_low;
				ADDR_THRESH_HIGH: next_rdata = mag_threshold_high;
				default: begin
					if (read_data) begin
						next_rdata = (rd_high ^ mag_config_c[C_BYTE_SWAP])
							? rd_word[15:8] : rd_word[7:0];
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			reg_rdata_out <= RESET_BYTE;
		end else begin
			reg_rdata_out <= next_rdata;
		end
	end

	// set pulse scheduling; the count runs in both modes so a switch starts clean
	// RULE_03 set pulse rate
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			set_count     <= SET_COUNT_ZERO;
			set_pulse_out <= 1'b0;
		end else begin
			set_pulse_out <= 1'b0;
			if (power_on_in) begin
				set_count     <= SET_COUNT_ZERO;
				set_pulse_out <= 1'b1;
			end else if (meas_valid_in) begin
				if (set_count == SET_PULSE_PERIOD - SET_COUNT_ONE) begin
					set_count     <= SET_COUNT_ZERO;
					set_pulse_out <= !mag_config_b[B_SET_RATE];
				end else begin
					set_count <= set_count + SET_COUNT_ONE;
				end
			end
		end
	end

	// data-ready level: set by a new sample, dropped by a data read
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			data_new <= 1'b0;
		end else if (meas_valid_in) begin
			data_new <= 1'b1;
		end else if (read_data) begin
			data_new <= 1'b0;
		end
	end

	// static configuration outputs and pins, all registered
	// RULE_01 one-shot needs general enable
	// RULE_04 lowpass select
	// RULE_09 self-test enable
	// RULE_10 data_ready_pin pin output
	// RULE_05 flag onto pin
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			offset_cancel_en_out      <= 1'b0;
			oneshot_offset_cancel_out <= 1'b0;
			lowpass_en_out            <= 1'b0;
			self_test_out             <= 1'b0;
			data_ready_pin_output_en_out        <= 1'b0;
			data_ready_pin_out        <= 1'b0;
			irq_pin_out               <= 1'b0;
		end else begin
			offset_cancel_en_out      <= mag_config_b[B_OFFSET_EN];
			oneshot_offset_cancel_out <= mag_config_b[B_ONESHOT_OFFSET]
				&& mag_config_b[B_OFFSET_EN];
			lowpass_en_out            <= mag_config_b[B_LOWPASS];
			self_test_out             <= mag_config_c[C_SELF_TEST];
			data_ready_pin_output_en_out        <= mag_config_c[C_DATA_READY_PIN_OUT_EN];
			data_ready_pin_out        <= mag_config_c[C_DATA_READY_PIN_OUT_EN] && data_new;
			irq_pin_out               <= mag_config_c[C_IRQ_TO_PIN] && int_bit;
		end
	end
endmodule

// [sim/mag_cfg_checker.sv]
// port checker for the magnetometer config and threshold bank
// assumes a single clock domain with synchronous active-high reset
`timescale 1ns/100ps
module mag_cfg_checker (
	input wire logic       clk_in,
	input wire logic       reset_in,
	input wire logic       reg_read_in,
	input wire logic       reg_write_in,
	input wire logic       meas_valid_in,
	input wire logic       power_on_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic       set_pulse_out,
	input wire logic       offset_cancel_en_out,
	input wire logic       oneshot_offset_cancel_out,
	input wire logic       lowpass_en_out,
	input wire logic       self_test_out,
	input wire logic       data_ready_pin_output_en_out,
	input wire logic       data_ready_pin_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	// config outputs may move one or two edges after a write
	sequence cfg_written;
		$past(reg_write_in) || $past(reg_write_in, 2);
	endsequence
	sequence set_cause;
		$past(power_on_in) || $past(meas_valid_in);
	endsequence
	oneshot_offset_a: assert property (oneshot_offset_cancel_out |-> offset_cancel_en_out)
		else $error("oneshot cancel without offset enable");
	power_set_a: assert property (power_on_in |=> set_pulse_out)
		else $error("no set pulse after power on");
	set_cause_a: assert property (set_pulse_out |-> set_cause)
		else $error("set pulse without cause");
	lowpass_write_a: assert property ($changed(lowpass_en_out) |-> cfg_written)
		else $error("lowpass moved without write");
	self_test_write_a: assert property ($changed(self_test_out) |-> cfg_written)
		else $error("self test moved without write");
	data_ready_pin_en_write_a: assert property ($changed(data_ready_pin_output_en_out) |-> cfg_written)
		else $error("data_ready_pin enable moved without write");
	data_ready_pin_gate_a: assert property (data_ready_pin_out |-> data_ready_pin_output_en_out
		|| $past(data_ready_pin_output_en_out))
		else $error("data ready pin while disabled");
	rdata_quiet_a: assert property (!reg_read_in |=> reg_rdata_out == 8'h00)
		else $error("read data outside read");
endmodule
bind mag_config_threshold_irq mag_cfg_checker mag_cfg_checker_inst (.clk_in, .reset_in,
	.reg_read_in, .reg_write_in, .meas_valid_in, .power_on_in, .reg_rdata_out, .set_pulse_out,
	.offset_cancel_en_out, .oneshot_offset_cancel_out, .lowpass_en_out, .self_test_out,
	.data_ready_pin_output_en_out, .data_ready_pin_out);

// [sim/mag_host_model.sv]
// host model issuing single-cycle register accesses to the bank
// assumes read data answers one cycle after the strobe edge
`timescale 1ns/100ps
module mag_host_model (
	input  wire logic       clk_in,
	input  wire logic [7:0] reg_rdata_in,
	output logic      [7:0] reg_addr_out,
	output logic            reg_write_out,
	output logic            reg_read_out,
	output logic      [7:0] reg_wdata_out,
	output logic            reg_from_i2c_out
);
	import mag_cfg_pkg::*;
	// idle bus at time zero
	initial begin
		{reg_addr_out, reg_write_out, reg_read_out, reg_wdata_out, reg_from_i2c_out} = '0;
	end
	// released lines show inverted values so stale data is never mistaken
	task automatic access(input logic wr, input logic [7:0] a, d, input logic i2c,
		output logic [7:0] q);
		logic [7:0] v;
		v = d;
		if (a == ADDR_CONFIG_B) v = d & CONFIG_B_MASK;
		if (a == ADDR_CONFIG_C) v = d & CONFIG_C_MASK;
		if (a == ADDR_IRQ_CONTROL) v = d & IRQ_CONTROL_MASK;
		if (a == ADDR_CONFIG_B && v[B_ONESHOT_OFFSET]) v[B_OFFSET_EN] = 1'h1;
		@(posedge clk_in);
		reg_addr_out <= a;
		reg_wdata_out <= v;
		reg_from_i2c_out <= i2c;
		reg_write_out <= wr;
		reg_read_out <= !wr;
		@(posedge clk_in);
		reg_write_out <= 1'h0;
		reg_read_out <= 1'h0;
		reg_addr_out <= ~a;
		reg_wdata_out <= ~v;
		#1 q = reg_rdata_in;
	endtask
endmodule

// [sim/test_mag_config_threshold_irq.sv]
// self-checking bench for the magnetometer config and threshold bank
// assumes the host model and checker files are compiled alongside
`timescale 1ns/100ps
module test_mag_config_threshold_irq;
	import mag_cfg_pkg::*;
	logic clk_in, reset_in, reg_write_in, reg_read_in, reg_from_i2c_in, meas_valid_in;
	logic range_overflow_in, power_on_in, set_pulse_out, offset_cancel_en_out;
	logic oneshot_offset_cancel_out, lowpass_en_out, self_test_out, data_ready_pin_output_en_out;
	logic data_ready_pin_out, irq_pin_out;
	logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
	logic [15:0] raw_x_in, raw_y_in, raw_z_in, offset_x_in;
	int fail_count, comparisons, cycles;
	mag_config_threshold_irq mag_config_threshold_irq_inst (.clk_in, .reset_in, .reg_addr_in,
		.reg_write_in, .reg_read_in, .reg_wdata_in, .reg_from_i2c_in, .reg_rdata_out,
		.meas_valid_in, .raw_x_in, .raw_y_in, .raw_z_in, .offset_x_in,
		.offset_y_in(16'h0000), .offset_z_in(16'h0000), .range_overflow_in, .power_on_in,
		.set_pulse_out, .offset_cancel_en_out, .oneshot_offset_cancel_out, .lowpass_en_out,
		.self_test_out, .data_ready_pin_output_en_out, .data_ready_pin_out, .irq_pin_out);
	mag_host_model mag_host_model_inst (.clk_in, .reg_rdata_in(reg_rdata_out),
		.reg_addr_out(reg_addr_in), .reg_write_out(reg_write_in), .reg_read_out(reg_read_in),
		.reg_wdata_out(reg_wdata_in), .reg_from_i2c_out(reg_from_i2c_in));
	task automatic report_and_stop();
		if (fail_count == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, d, input logic i2c = 1'h0);
		logic [7:0] q;
		mag_host_model_inst.access(1'h1, a, d, i2c, q);
	endtask
	task automatic rd(input logic [7:0] a, e, input logic i2c = 1'h0);
		logic [7:0] q;
		mag_host_model_inst.access(1'h0, a, 8'h00, i2c, q);
		chk($sformatf("reg %h", a), e, q);
	endtask
	// one measurement pulse; released samples are inverted
	task automatic meas(input logic [15:0] x, y, z, o, input logic v = 1'h0);
		@(posedge clk_in);
		meas_valid_in <= 1'h1;
		{raw_x_in, raw_y_in, raw_z_in, offset_x_in, range_overflow_in} <= {x, y, z, o, v};
		@(posedge clk_in);
		meas_valid_in <= 1'h0;
		{raw_x_in, raw_y_in, raw_z_in} <= ~{x, y, z};
		#1;
	endtask
	task automatic pulse_on();
		@(posedge clk_in);
		power_on_in <= 1'h1;
		@(posedge clk_in);
		power_on_in <= 1'h0;
		#1 chk("set pulse", 8'h01, {7'h00, set_pulse_out});
	endtask
	// clock and hang guard
	initial begin
		clk_in = 1'h0;
		forever #10 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			report_and_stop();
		end
	end
	// main sequence
	initial begin
		{reset_in, meas_valid_in, range_overflow_in, power_on_in} = 4'h8;
		{raw_x_in, raw_y_in, raw_z_in, offset_x_in} = '0;
		repeat (10) @(posedge clk_in);
		reset_in <= 1'h0;
		for (int a = 8'h61; a <= 8'h65; a++) rd(8'(a), (a == 8'h64) ? 8'h01 : 8'h00);
		wr(ADDR_CONFIG_B, 8'h13);
		wr(ADDR_CONFIG_C, 8'h03);
		rd(ADDR_CONFIG_C, 8'h03);
		chk("outputs", 8'h1f, {3'h0, lowpass_en_out, offset_cancel_en_out,
			oneshot_offset_cancel_out, self_test_out, data_ready_pin_output_en_out});
		meas(16'h1234, 16'h0000, 16'h0000, 16'h0000);
		@(posedge clk_in);
		#1 chk("data_ready_pin pin", 8'h01, {7'h00, data_ready_pin_out});
		wr(ADDR_CONFIG_B, 8'h00);
		wr(ADDR_CONFIG_C, 8'h08);
		rd(8'h68, 8'h12);
		wr(ADDR_CONFIG_C, 8'h10);
		rd(8'h68, 8'h34);
		meas(16'h5678, 16'h0000, 16'h0000, 16'h0000);
		rd(8'h69, 8'h12);
		wr(ADDR_CONFIG_C, 8'h40);
		wr(ADDR_THRESH_LOW, 8'h10);
		wr(ADDR_THRESH_HIGH, 8'h00);
		wr(ADDR_IRQ_CONTROL, 8'he7);
		meas(16'h0011, 16'hffef, 16'h0010, 16'h0000);
		@(posedge clk_in);
		#1 chk("irq pin", 8'h01, {7'h00, irq_pin_out});
		rd(ADDR_IRQ_SOURCE, 8'h89);
		rd(ADDR_IRQ_SOURCE, 8'h00);
		wr(ADDR_IRQ_CONTROL, 8'h00);
		meas(16'h7fff, 16'h0000, 16'h0000, 16'h0000, 1'h1);
		rd(ADDR_IRQ_SOURCE, 8'h03);
		rd(ADDR_IRQ_SOURCE, 8'h01);
		wr(ADDR_IRQ_CONTROL, 8'h47);
		meas(16'h0100, 16'h0000, 16'h0000, 16'h0000);
		rd(ADDR_IRQ_SOURCE, 8'h00);
		wr(ADDR_IRQ_CONTROL, 8'h85);
		meas(16'h0100, 16'h0000, 16'h0000, 16'h0000);
		rd(ADDR_IRQ_SOURCE, 8'h81);
		rd(ADDR_IRQ_SOURCE, 8'h81);
		meas(16'h0000, 16'h0000, 16'h0000, 16'h0000);
		rd(ADDR_IRQ_SOURCE, 8'h00);
		wr(ADDR_IRQ_CONTROL, 8'h87);
		wr(ADDR_CONFIG_B, 8'h08);
		meas(16'h0020, 16'h0000, 16'h0000, 16'h0018);
		rd(ADDR_IRQ_SOURCE, 8'h00);
		wr(ADDR_CONFIG_B, 8'h00);
		meas(16'h0020, 16'h0000, 16'h0000, 16'h0018);
		rd(ADDR_IRQ_SOURCE, 8'h81);
		wr(ADDR_CONFIG_C, 8'h20);
		wr(ADDR_THRESH_LOW, 8'h55, 1'h1);
		rd(ADDR_THRESH_LOW, 8'h00, 1'h1);
		rd(ADDR_THRESH_LOW, 8'h10);
		wr(ADDR_CONFIG_C, 8'h00);
		wr(ADDR_IRQ_CONTROL, 8'h83);
		meas(16'h0100, 16'h0000, 16'h0000, 16'h0000);
		rd(ADDR_IRQ_SOURCE, 8'h80);
		rd(ADDR_IRQ_SOURCE, 8'h01);
		pulse_on();
		repeat (63) meas(16'h0000, 16'h0000, 16'h0000, 16'h0000);
		chk("set pulse", 8'h01, {7'h00, set_pulse_out});
		wr(ADDR_CONFIG_B, 8'h04);
		pulse_on();
		repeat (63) meas(16'h0000, 16'h0000, 16'h0000, 16'h0000);
		chk("set pulse", 8'h00, {7'h00, set_pulse_out});
		report_and_stop();
	end
endmodule
